// ---- spp_pkg.sv ----
package spp_pkg;

  // ----------------------------------------------------------------
  // Serial frame
  // ----------------------------------------------------------------
  localparam int         PTR_W         = 22;
  localparam int         BUF_DEPTH_DEF = 8;
  localparam logic [4:0] CNT_CMD_LAST  = 5'h03;
  localparam logic [4:0] CNT_MID_LAST  = 5'h0B;
  localparam logic [4:0] CNT_OUT_BASE  = 5'h0C;
  localparam logic [4:0] CNT_LAST      = 5'h13;

  localparam logic [3:0] CMD_CORE        = 4'h0;
  localparam logic [3:0] CMD_READ_INC    = 4'h9;
  localparam logic [3:0] CMD_WRITE_NOINC = 4'hC;
  localparam logic [3:0] CMD_WRITE_INC   = 4'hD;
  localparam logic [3:0] CMD_WRITE_PROG  = 4'hF;

  // ----------------------------------------------------------------
  // Core instructions understood by the port
  // ----------------------------------------------------------------
  localparam logic [7:0]  OPC_MOVLW    = 8'h0E;
  localparam logic [7:0]  OPC_GOTO     = 8'hEF;
  localparam logic [3:0]  OPC_GOTO_2ND = 4'hF;
  localparam logic [15:0] INS_WR_TPU   = 16'h6EF8;
  localparam logic [15:0] INS_WR_TPH   = 16'h6EF7;
  localparam logic [15:0] INS_WR_TPL   = 16'h6EF6;
  localparam logic [15:0] INS_INC_TPL  = 16'h2AF6;
  localparam logic [15:0] INS_SET_PGM  = 16'h8EA6;
  localparam logic [15:0] INS_SET_CFG  = 16'h8CA6;
  localparam logic [15:0] INS_CLR_PGM  = 16'h9EA6;
  localparam logic [15:0] INS_CLR_CFG  = 16'h9CA6;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [PTR_W-1:0] BOOT_LO        = 22'h000000;
  localparam logic [PTR_W-1:0] BOOT_HI        = 22'h0007FF;
  localparam logic [PTR_W-1:0] ID_LO          = 22'h200000;
  localparam logic [PTR_W-1:0] ID_HI          = 22'h200007;
  localparam logic [PTR_W-1:0] CFG_LO         = 22'h300000;
  localparam logic [PTR_W-1:0] CFG_HI         = 22'h30000F;
  localparam logic [PTR_W-1:0] CODE_PROT_ADDR = 22'h300008;
  localparam logic [PTR_W-1:0] CFG6H_ADDR     = 22'h30000B;
  localparam logic [PTR_W-1:0] SINGLE_PANEL   = 22'h3C0006;
  localparam logic [PTR_W-1:0] PROT_LIMIT     = 22'h100000;
  localparam int               CFG_WP_BIT     = 5;
  localparam logic [7:0]       BYTE_ERASED    = 8'hFF;
  localparam logic [7:0]       BYTE_ZERO      = 8'h00;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam logic [3:0]  REG_CTRL     = 4'h0;
  localparam logic [3:0]  REG_PTR      = 4'h4;
  localparam logic [3:0]  REG_STAT     = 4'h8;
  localparam logic [31:0] CTRL_RST     = 32'h00000001;
  localparam int          CTRL_EN_BIT  = 0;
  localparam int          STAT_SINGLE  = 0;
  localparam int          STAT_WP      = 1;
  localparam int          STAT_BLOCK   = 2;
  localparam int          STAT_BUSY    = 3;
  localparam int          STAT_CFG     = 4;

  typedef enum logic [2:0] {
    SPP_IDLE  = 3'b001,
    SPP_FETCH = 3'b010,
    SPP_PROG  = 3'b100
  } spp_state_type;

  function automatic logic spp_in_range(input logic [PTR_W-1:0] a,
                                        input logic [PTR_W-1:0] lo,
                                        input logic [PTR_W-1:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : spp_in_range

endpackage : spp_pkg

// ---- spp_pin_sync.sv ----
`timescale 1ns/1ns
module spp_pin_sync
  import spp_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic clk_pin,
  input  wire logic data_pin,
  output logic      clk_rise,
  output logic      clk_fall,
  output logic      data_level
);

  logic clk_s1_ff;
  logic clk_s2_ff;
  logic clk_s3_ff;
  logic data_s1_ff;
  logic data_s2_ff;

  // Edges are taken only from the second stage and its delayed copy
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_s1_ff  <= 1'b0;
      clk_s2_ff  <= 1'b0;
      clk_s3_ff  <= 1'b0;
      data_s1_ff <= 1'b0;
      data_s2_ff <= 1'b0;
    end else begin
      clk_s1_ff  <= clk_pin;
      clk_s2_ff  <= clk_s1_ff;
      clk_s3_ff  <= clk_s2_ff;
      data_s1_ff <= data_pin;
      data_s2_ff <= data_s1_ff;
    end
  end

  assign clk_rise   = clk_s2_ff & ~clk_s3_ff;
  assign clk_fall   = ~clk_s2_ff & clk_s3_ff;
  assign data_level = data_s2_ff;

endmodule : spp_pin_sync

// ---- spp_serial_port.sv ----
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
module spp_serial_port
  import spp_pkg::*;
#(
  parameter int BUF_DEPTH = BUF_DEPTH_DEF
)
(
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             program_serial_clock,
  input  wire logic             program_serial_data_in,
  output logic                  program_serial_data_out,
  output logic                  program_serial_data_oe,
  output logic [PTR_W-1:0]      mem_addr,
  output logic                  mem_rd,
  input  wire logic [7:0]       mem_rdata,
  output logic                  mem_wr,
  output logic [7:0]            mem_wdata,
  input  wire logic [3:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [31:0]           reg_rdata
);

  localparam int BUF_AW = $clog2(BUF_DEPTH);

  generate
    if (BUF_DEPTH < 2 || BUF_DEPTH > 256 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_chk
      $error("BUF_DEPTH must be a power of two from 2 to 256");
    end
  endgenerate

  logic                 clk_rise;
  logic                 clk_fall;
  logic                 data_lvl;
  logic [4:0]           cnt_ff;
  logic [3:0]           cmd_sr_ff;
  logic [3:0]           cmd_ff;
  logic [15:0]          op_sr_ff;
  logic [31:0]          ctrl_ff;
  logic [7:0]           w_ff;
  logic [PTR_W-1:0]     tp_ff;
  logic [PTR_W-1:0]     pc_ff;
  logic [7:0]           goto_lo_ff;
  logic                 goto_pend_ff;
  logic                 pgm_sel_ff;
  logic                 cfg_sel_ff;
  logic                 single_panel_ff;
  logic                 cfg_wp_ff;
  logic                 wr_block_ff;
  logic [7:0]           latch_ff;
  logic [7:0]           buf_mem [BUF_DEPTH];
  logic [BUF_AW-1:0]    prog_idx_ff;
  logic [PTR_W-1:0]     prog_base_ff;
  spp_state_type        state_ff;
  logic                 mem_rd_ff;
  logic                 mem_wr_ff;
  logic [PTR_W-1:0]     mem_addr_ff;
  logic [7:0]           mem_wdata_ff;
  logic                 out_ff;
  logic                 oe_ff;
  logic [31:0]          reg_rdata_ff;

  logic                 port_en;
  logic [3:0]           cmd_word;
  logic [15:0]          op_word;
  logic                 cmd_cap;
  logic                 op_done;
  logic                 is_core;
  logic                 tw_go;
  logic                 cfg_try;
  logic                 cfg_go;
  logic                 prog_go;
  logic                 rd_go;
  logic [7:0]           sel_byte;
  logic [BUF_AW-1:0]    buf_idx;
  logic [PTR_W-1:0]     panel_base;
  logic [4:0]           out_pos;

  spp_pin_sync u_sync (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .clk_pin    (program_serial_clock),
    .data_pin   (program_serial_data_in),
    .clk_rise   (clk_rise),
    .clk_fall   (clk_fall),
    .data_level (data_lvl)
  );

  // ----------------------------------------------------------------
  // Serial framing: 4 command bits then 16 operand bits
  // ----------------------------------------------------------------
  assign port_en  = ctrl_ff[CTRL_EN_BIT];
  assign cmd_word = {data_lvl, cmd_sr_ff[3:1]};
  assign op_word  = {data_lvl, op_sr_ff[15:1]};
  assign cmd_cap  = port_en & clk_fall & (cnt_ff == CNT_CMD_LAST);
  assign op_done  = port_en & clk_fall & (cnt_ff == CNT_LAST);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 5'h00;
    end else if (!port_en) begin
      cnt_ff <= 5'h00;
    end else if (clk_fall) begin
      cnt_ff <= (cnt_ff == CNT_LAST) ? 5'h00 : cnt_ff + 5'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_sr_ff <= 4'h0;
      cmd_ff    <= CMD_CORE;
      op_sr_ff  <= 16'h0000;
    end else if (port_en && clk_fall) begin
      if (cnt_ff <= CNT_CMD_LAST) begin
        cmd_sr_ff <= cmd_word;
      end else begin
        op_sr_ff <= op_word;
      end
      if (cmd_cap) begin
        cmd_ff <= cmd_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  assign is_core    = op_done && (cmd_ff == CMD_CORE);
  assign sel_byte   = tp_ff[0] ? op_word[15:8] : op_word[7:0];
  assign buf_idx    = tp_ff[BUF_AW-1:0];
  assign panel_base = tp_ff & ~PTR_W'(BUF_DEPTH - 1);
  assign tw_go      = op_done && !wr_block_ff && (state_ff == SPP_IDLE) &&
                      ((cmd_ff == CMD_WRITE_INC) || (cmd_ff == CMD_WRITE_NOINC) ||
                       (cmd_ff == CMD_WRITE_PROG));
  assign cfg_try    = tw_go && (cmd_ff == CMD_WRITE_PROG) && cfg_sel_ff;
  assign cfg_go     = cfg_try && !cfg_wp_ff && spp_in_range(tp_ff, CFG_LO, CFG_HI);
  // Only the boot block and ID panels accept programming here
  assign prog_go    = tw_go && (cmd_ff == CMD_WRITE_PROG) && !cfg_sel_ff &&
                      single_panel_ff &&
                      (spp_in_range(panel_base, BOOT_LO, BOOT_HI) ||
                       spp_in_range(panel_base, ID_LO, ID_HI));
  assign rd_go      = cmd_cap && (cmd_word == CMD_READ_INC) && (state_ff == SPP_IDLE);

  // ----------------------------------------------------------------
  // Core registers reached through command 0000
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      w_ff         <= BYTE_ZERO;
      pc_ff        <= BOOT_LO;
      goto_lo_ff   <= BYTE_ZERO;
      goto_pend_ff <= 1'b0;
      pgm_sel_ff   <= 1'b0;
      cfg_sel_ff   <= 1'b0;
    end else if (is_core) begin
      goto_pend_ff <= 1'b0;
      if (goto_pend_ff && op_word[15:12] == OPC_GOTO_2ND) begin
        pc_ff <= {1'b0, op_word[11:0], goto_lo_ff, 1'b0};
      end else if (op_word[15:8] == OPC_GOTO) begin
        goto_lo_ff   <= op_word[7:0];
        goto_pend_ff <= 1'b1;
      end else if (op_word[15:8] == OPC_MOVLW) begin
        w_ff <= op_word[7:0];
      end
      case (op_word)
        INS_SET_PGM: pgm_sel_ff <= 1'b1;
        INS_CLR_PGM: pgm_sel_ff <= 1'b0;
        INS_SET_CFG: cfg_sel_ff <= 1'b1;
        INS_CLR_CFG: cfg_sel_ff <= 1'b0;
        default:     pgm_sel_ff <= pgm_sel_ff;
      endcase
    end
  end

  // Table pointer: core moves, read post-increment, buffered write +2
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tp_ff <= BOOT_LO;
    end else if (rd_go) begin
      tp_ff <= tp_ff + PTR_W'(1);
    end else if (tw_go && cmd_ff == CMD_WRITE_INC) begin
      tp_ff <= tp_ff + PTR_W'(2);
    end else if (is_core) begin
      case (op_word)
        INS_WR_TPU:  tp_ff[21:16] <= w_ff[5:0];
        INS_WR_TPH:  tp_ff[15:8]  <= w_ff;
        INS_WR_TPL:  tp_ff[7:0]   <= w_ff;
        INS_INC_TPL: tp_ff[7:0]   <= tp_ff[7:0] + 8'h01;
        default:     tp_ff        <= tp_ff;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Write buffer and protection state
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (tw_go && !cfg_sel_ff) begin
      buf_mem[buf_idx]                 <= op_word[7:0];
      buf_mem[buf_idx + BUF_AW'(1)]    <= op_word[15:8];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      single_panel_ff <= 1'b0;
      cfg_wp_ff       <= 1'b0;
      wr_block_ff     <= 1'b0;
    end else begin
      if (tw_go && cmd_ff == CMD_WRITE_NOINC && tp_ff == SINGLE_PANEL) begin
        single_panel_ff <= (sel_byte == BYTE_ZERO);
      end
      if (cfg_go && tp_ff == CFG6H_ADDR && !sel_byte[CFG_WP_BIT]) begin
        cfg_wp_ff <= 1'b1;
      end
      // Protection landing on the running code locks out table writes
      if (cfg_go && tp_ff == CODE_PROT_ADDR && sel_byte != BYTE_ERASED &&
          pc_ff < PROT_LIMIT) begin
        wr_block_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory port sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff     <= SPP_IDLE;
      mem_rd_ff    <= 1'b0;
      mem_wr_ff    <= 1'b0;
      mem_addr_ff  <= BOOT_LO;
      mem_wdata_ff <= BYTE_ZERO;
      latch_ff     <= BYTE_ZERO;
      prog_idx_ff  <= '0;
      prog_base_ff <= BOOT_LO;
    end else begin
      mem_rd_ff <= 1'b0;
      mem_wr_ff <= 1'b0;
      case (state_ff)
        SPP_IDLE: begin
          if (rd_go) begin
            mem_rd_ff   <= 1'b1;
            mem_addr_ff <= tp_ff;
            state_ff    <= SPP_FETCH;
          end else if (cfg_go) begin
            mem_wr_ff    <= 1'b1;
            mem_addr_ff  <= tp_ff;
            mem_wdata_ff <= sel_byte;
          end else if (prog_go) begin
            prog_base_ff <= panel_base;
            prog_idx_ff  <= '0;
            state_ff     <= SPP_PROG;
          end
        end
        SPP_FETCH: begin
          // Read data is valid the cycle after the strobe
          if (!mem_rd_ff) begin
            latch_ff <= mem_rdata;
            state_ff <= SPP_IDLE;
          end
        end
        SPP_PROG: begin
          mem_wr_ff    <= 1'b1;
          mem_addr_ff  <= prog_base_ff | PTR_W'(prog_idx_ff);
          mem_wdata_ff <= buf_mem[prog_idx_ff];
          prog_idx_ff  <= prog_idx_ff + BUF_AW'(1);
          if (prog_idx_ff == BUF_AW'(BUF_DEPTH - 1)) begin
            state_ff <= SPP_IDLE;
          end
        end
        default: state_ff <= SPP_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Data pin turnaround and shift-out
  // ----------------------------------------------------------------
  assign out_pos = cnt_ff - CNT_OUT_BASE;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      oe_ff  <= 1'b0;
      out_ff <= 1'b0;
    end else if (!port_en) begin
      oe_ff <= 1'b0;
    end else if (clk_fall && cnt_ff == CNT_MID_LAST && cmd_ff == CMD_READ_INC) begin
      oe_ff  <= 1'b1;
      out_ff <= latch_ff[0];
    end else if (op_done) begin
      oe_ff <= 1'b0;
    end else if (clk_rise && oe_ff && cnt_ff >= CNT_OUT_BASE) begin
      out_ff <= latch_ff[out_pos[2:0]];
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= CTRL_RST;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      ctrl_ff <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_ff <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: reg_rdata_ff <= ctrl_ff;
        REG_PTR:  reg_rdata_ff <= 32'(tp_ff);
        REG_STAT: reg_rdata_ff <= {27'h0000000, cfg_sel_ff, state_ff != SPP_IDLE,
                                   wr_block_ff, cfg_wp_ff, single_panel_ff};
        default:  reg_rdata_ff <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_ff <= 32'h00000000;
    end
  end

  assign program_serial_data_out = out_ff;
  assign program_serial_data_oe  = oe_ff;
  assign mem_addr                = mem_addr_ff;
  assign mem_rd                  = mem_rd_ff;
  assign mem_wr                  = mem_wr_ff;
  assign mem_wdata               = mem_wdata_ff;
  assign reg_rdata               = reg_rdata_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  AST_CMD_LSB_FIRST: assert property (
    cmd_cap |=> cmd_ff == {$past(data_lvl), $past(cmd_sr_ff[3:1])})
    else $error("command not assembled LSB first");

  AST_READ_ADDR_INC: assert property (
    rd_go |=> mem_rd_ff && tp_ff == mem_addr_ff + PTR_W'(1))
    else $error("read did not post-increment pointer by one");

  AST_READ_LATCH: assert property (
    mem_rd_ff |-> ##2 latch_ff == $past(mem_rdata))
    else $error("table latch not loaded from memory");

  AST_OE_START: assert property (
    $rose(oe_ff) |-> cnt_ff == CNT_OUT_BASE && cmd_ff == CMD_READ_INC)
    else $error("data pin turned to output at wrong clock");

  AST_OE_END: assert property (
    $fell(oe_ff) && port_en |-> cnt_ff == 5'h00 && $past(cnt_ff) == CNT_LAST)
    else $error("data pin released at wrong clock");

  AST_OUT_BIT: assert property (
    clk_rise && oe_ff && cnt_ff >= CNT_OUT_BASE && !op_done
      |=> out_ff == latch_ff[$past(out_pos[2:0])])
    else $error("output bit does not follow latch order");

  AST_CFG_BYTE: assert property (
    cfg_go |=> mem_wr_ff && mem_wdata_ff == ($past(tp_ff[0]) ? $past(op_word[15:8])
                                                              : $past(op_word[7:0])))
    else $error("wrong configuration byte written");

  AST_CFG_WP: assert property (
    cfg_try && cfg_wp_ff |=> !mem_wr_ff ##1 !mem_wr_ff)
    else $error("configuration written while protected");

  AST_BOOT_RANGE: assert property (
    mem_wr_ff && !cfg_sel_ff |-> spp_in_range(mem_addr_ff, BOOT_LO, BOOT_HI) ||
                                 spp_in_range(mem_addr_ff, ID_LO, ID_HI))
    else $error("panel write outside boot or ID range");

  AST_BUF_INC2: assert property (
    tw_go && cmd_ff == CMD_WRITE_INC |=> tp_ff == $past(tp_ff) + PTR_W'(2))
    else $error("buffered write did not add two to pointer");

  AST_BLOCKED: assert property (
    op_done && wr_block_ff && cmd_ff == CMD_WRITE_PROG |=> !mem_wr_ff && state_ff == SPP_IDLE)
    else $error("table write accepted while blocked");

  COV_READ:  cover property (rd_go ##[1:300] $fell(oe_ff));
  COV_CFG:   cover property (cfg_go ##1 mem_wr_ff);
  COV_PROG:  cover property (prog_go ##1 state_ff == SPP_PROG [*8]);
  COV_WPROT: cover property (cfg_try && cfg_wp_ff);

endmodule : spp_serial_port

// ---- spp_prog_model.sv ----
`timescale 1ns/1ns
// ------------------------------------------------------------
// Programmer side of the two-wire port
// ------------------------------------------------------------
module spp_prog_model
  import spp_pkg::*;
(
  output logic      sclk,
  output logic      sdata,
  input  wire logic line
);
  initial begin
    sclk  = 1'b0;
    sdata = 1'b0;
  end

  // Clock stands low between frames; a released data line toggles
  task automatic frame(input logic [3:0] cmd, input logic [15:0] op, input int hold,
                       output logic [7:0] rd);
    logic [19:0] bits;
    bits = {op, cmd};
    rd = 8'h00;
    for (int i = 0; i < 20; i++) begin
      sclk = 1'b1;
      if (cmd == CMD_READ_INC && i >= 12) sdata = ~sdata;
      else sdata = bits[i];
      #(40 + ((i == 3) ? hold : 0));
      if (i >= 12) rd[i-12] = line;
      sclk = 1'b0;
      #40;
      if (i == 11) #48;
    end
  endtask : frame
endmodule : spp_prog_model

// ---- tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  import spp_pkg::*;
  logic             ref_clk, reset_n, sclk, sdata_p, d_out, d_oe, mem_rd, mem_wr;
  logic             reg_wr, reg_rd;
  wire              line;
  logic [3:0]       reg_addr;
  logic [31:0]      reg_wdata, reg_rdata, q;
  logic [PTR_W-1:0] mem_addr, wr_addr, rd_addr;
  logic [7:0]       mem_rdata, mem_wdata, wr_data, b;
  int               err_total, checked, wr_cnt, rd_cnt, n;

  // ------------------------------------------------------------
  // Harness
  // ------------------------------------------------------------
  assign line = d_oe ? d_out : sdata_p;
  always #4 ref_clk = ~ref_clk;
  spp_serial_port u_spp_serial_port (.ref_clk(ref_clk), .reset_n(reset_n),
    .program_serial_clock(sclk), .program_serial_data_in(line),
    .program_serial_data_out(d_out), .program_serial_data_oe(d_oe),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  spp_prog_model u_spp_prog_model (.sclk(sclk), .sdata(sdata_p), .line(line));

  function automatic logic [7:0] mbyte(input logic [PTR_W-1:0] a);
    return a[7:0] ^ {2'b00, a[21:16]};
  endfunction : mbyte

  // Memory answers the cycle after the strobe
  always @(posedge ref_clk) begin
    mem_rdata <= mbyte(mem_addr);
    if (mem_rd) begin
      rd_cnt++;
      rd_addr = mem_addr;
    end
    if (mem_wr) begin
      wr_cnt++;
      wr_addr = mem_addr;
      wr_data = mem_wdata;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  task automatic reg_rw(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= w;
    reg_rd    <= ~w;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask : reg_rw

  task automatic core(input logic [15:0] ins);
    u_spp_prog_model.frame(CMD_CORE, ins, 0, b);
  endtask : core

  task automatic set_ptr(input logic [PTR_W-1:0] a);
    core({OPC_MOVLW, 2'b00, a[21:16]});
    core(INS_WR_TPU);
    core({OPC_MOVLW, a[15:8]});
    core(INS_WR_TPH);
    core({OPC_MOVLW, a[7:0]});
    core(INS_WR_TPL);
  endtask : set_ptr

  // One config byte, then the hold NOP and four spacing NOPs
  task automatic prog_cfg(input logic [15:0] op);
    u_spp_prog_model.frame(CMD_WRITE_PROG, op, 0, b);
    u_spp_prog_model.frame(CMD_CORE, 16'h0000, 400, b);
    repeat (4) core(16'h0000);
  endtask : prog_cfg

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    reg_rw(1'b0, REG_CTRL, 32'h0);
    check(q, CTRL_RST);
    reg_rw(1'b1, REG_STAT, 32'hFFFFFFFF);
    reg_rw(1'b0, REG_STAT, 32'h0);
    check(q, 32'h0);
    reg_rw(1'b0, 4'hC, 32'h0);
    check(q, 32'h0);
  endtask : t_regs

  task automatic t_read;
    set_ptr(22'h3FFFFF);
    for (int i = 0; i < 2; i++) begin
      n = rd_cnt;
      u_spp_prog_model.frame(CMD_READ_INC, 16'h0000, 0, b);
      check(rd_cnt, n + 1);
      check(rd_addr, i ? 22'h000000 : 22'h3FFFFF);
      check(b, mbyte(rd_addr));
      reg_rw(1'b0, REG_PTR, 32'h0);
      check(q, i ? 32'h1 : 32'h0);
    end
  endtask : t_read

  task automatic t_cfg;
    core(INS_SET_PGM);
    core(INS_SET_CFG);
    core({OPC_GOTO, 8'h00});
    core({OPC_GOTO_2ND, 12'h800});
    set_ptr(CFG_LO);
    n = wr_cnt;
    prog_cfg(16'hBBAA);
    check(wr_cnt, n + 1);
    check({wr_addr, wr_data}, {CFG_LO, 8'hAA});
    core(INS_INC_TPL);
    prog_cfg(16'hBBAA);
    check({wr_addr, wr_data}, {22'h300001, 8'hBB});
    set_ptr(CFG6H_ADDR);
    prog_cfg(16'h00FF);
    check(wr_data, 8'h00);
    reg_rw(1'b0, REG_STAT, 32'h0);
    check(q[STAT_WP], 1'b1);
    n = wr_cnt;
    set_ptr(CFG_LO);
    prog_cfg(16'h1234);
    check(wr_cnt, n);
  endtask : t_cfg

  task automatic t_dis;
    reg_rw(1'b1, REG_CTRL, 32'h0);
    n = rd_cnt;
    u_spp_prog_model.frame(CMD_READ_INC, 16'h0000, 0, b);
    check(rd_cnt, n);
    check(d_oe, 1'b0);
    reg_rw(1'b1, REG_CTRL, CTRL_RST);
    // A disabled port must not have moved the pointer either
    reg_rw(1'b0, REG_PTR, 32'h0);
    check(q, 32'h1);
  endtask : t_dis

  // Single panel mode, then one boot panel inside the range and one outside it
  task automatic t_boot;
    core(INS_SET_CFG);
    set_ptr(SINGLE_PANEL);
    u_spp_prog_model.frame(CMD_WRITE_NOINC, 16'h0000, 0, b);
    reg_rw(1'b0, REG_STAT, 32'h0);
    check(q[STAT_SINGLE], 1'b1);
    core(INS_CLR_CFG);
    set_ptr(22'h000100);
    n = wr_cnt;
    for (int i = 0; i < 3; i++) begin
      u_spp_prog_model.frame(CMD_WRITE_INC, {8'(2 * i + 1), 8'(2 * i)}, 0, b);
    end
    reg_rw(1'b0, REG_PTR, 32'h0);
    check(q, 32'h106);
    prog_cfg(16'h0706);
    check(wr_cnt, n + 8);
    check({wr_addr, wr_data}, {22'h000107, 8'h07});
    set_ptr(22'h000800);
    n = wr_cnt;
    prog_cfg(16'h0908);
    check(wr_cnt, n);
  endtask : t_boot

  // Second reset clears the sticky flags; code protect with the counter low
  task automatic t_block;
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    reg_rw(1'b0, REG_STAT, 32'h0);
    check(q, 32'h0);
    core(INS_SET_PGM);
    core(INS_SET_CFG);
    set_ptr(CODE_PROT_ADDR);
    prog_cfg(16'h00FE);
    reg_rw(1'b0, REG_STAT, 32'h0);
    check(q[STAT_BLOCK], 1'b1);
    n = wr_cnt;
    set_ptr(CFG_LO);
    prog_cfg(16'h1234);
    check(wr_cnt, n);
  endtask : t_block

  initial begin
    {ref_clk, reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {err_total, checked, wr_cnt, rd_cnt} = '0;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_regs();
    t_read();
    t_dis();
    t_cfg();
    t_boot();
    t_block();
    end_of_test();
  end

  // Bounded watchdog so a hang still reaches the verdict
  initial begin
    repeat (90000) @(posedge ref_clk);
    err_total++;
    end_of_test();
  end
endmodule : tb_top
